// >>> design/prx_consts.vh
// constants for the receive-side mac interface block
// assumes a single 100 mhz system clock drives all logic
`ifndef PRX_CONSTS_VH
`define PRX_CONSTS_VH

`define PRX_SYS_CLK_KHZ     100000
`define PRX_MII_CLK_KHZ     2500
`define PRX_RMII_CLK_KHZ    50000
`define PRX_MII_HALF        (`PRX_SYS_CLK_KHZ / (2 * `PRX_MII_CLK_KHZ))
`define PRX_RMII_HALF       (`PRX_SYS_CLK_KHZ / (2 * `PRX_RMII_CLK_KHZ))
`define PRX_RMII_REPEAT     10
`define PRX_MODE_MII        2'h0
`define PRX_MODE_RMII       2'h1
`define PRX_MODE_RGMII      2'h2

`endif

// >>> design/prx_rx_mac_if.v
// receive-side mac interface: drives mii, rmii or rgmii receive pins
// assumes mode and repeater select are static while out of reset
// Behaviour
// - receive data and control outputs change together with the rising edge of the receive clock, save the rgmii control line, which changes on both edges.
// - receive data is meaningful only while data-valid is high; in mii and rmii modes it reads zero otherwise.
// - mii mode delivers four data bits per clock, rmii two bits on the lowest two lines.
// - in rmii mode the data-valid pin carries carrier sense or'ed with data valid.
// - a repeater select turns the rmii combined indication into plain data valid.
// - in rgmii mode the control line shows data valid after the rising edge and error after the falling edge.
// - the block drives a 2.5 mhz receive clock in mii and rgmii modes and 50 mhz in rmii mode.
// - in mii and rmii modes receive error goes high for every reception error, idle errors included, on the rising clock edge; rgmii holds it low.
`timescale 1ns/1ps
`include "prx_consts.vh"

module prx_rx_mac_if #(
   parameter MII_HALF    = `PRX_MII_HALF,
   parameter RMII_HALF   = `PRX_RMII_HALF,
   parameter RMII_REPEAT = `PRX_RMII_REPEAT
) (
   input  wire       ref_clk_in,
   input  wire       sys_rst_in,
   input  wire [1:0] mode_in,
   input  wire       rmii_dv_only_in,
   input  wire [3:0] rx_nib_in,
   input  wire       rx_nib_valid_in,
   input  wire       rx_err_in,
   input  wire       rx_crs_in,
   output reg        rx_nib_take_out,
   output reg        rx_clk_out,
   output reg  [3:0] rx_data_out,
   output reg        rx_dv_out,
   output reg        rx_er_out
);

   reg  [5:0] div_q;
   reg  [3:0] rep_q;
   reg        sel_q;
   reg  [3:0] hold_q;
   reg        hold_dv_q;
   reg        hold_er_q;
   reg        hold_crs_q;
   wire       is_rmii;
   wire       is_rgmii;
   wire [5:0] half_m1;
   wire       half_done;
   wire       rise;
   wire       fall;
   wire       rmii_load;
   wire       rmii_dv;

   assign is_rmii   = (mode_in == `PRX_MODE_RMII);
   assign is_rgmii  = (mode_in == `PRX_MODE_RGMII);
   // rmii runs the pin clock at 50 mhz, the others at 2.5 mhz
   assign half_m1   = is_rmii ? RMII_HALF[5:0] - 6'h01
                              : MII_HALF[5:0] - 6'h01;
   assign half_done = (div_q == half_m1);
   assign rise      = half_done && !rx_clk_out;
   assign fall      = half_done && rx_clk_out;
   // a fresh nibble every two dibits of ten repeats each
   assign rmii_load = rise && (rep_q == 4'h0) && !sel_q;
   assign rmii_dv   = rmii_dv_only_in ? hold_dv_q
                                      : (hold_dv_q | hold_crs_q);

   always @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         div_q      <= 6'h00;
         rx_clk_out <= 1'b0;
      end else if (half_done) begin
         div_q      <= 6'h00;
         rx_clk_out <= !rx_clk_out;
      end else begin
         div_q      <= div_q + 6'h01;
      end
   end

   always @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         rep_q      <= 4'h0;
         sel_q      <= 1'b0;
         hold_q     <= 4'h0;
         hold_dv_q  <= 1'b0;
         hold_er_q  <= 1'b0;
         hold_crs_q <= 1'b0;
      end else if (is_rmii && rise) begin
         if (rep_q == RMII_REPEAT[3:0] - 4'h1) begin
            rep_q <= 4'h0;
            sel_q <= !sel_q;
         end else begin
            rep_q <= rep_q + 4'h1;
         end
         if (rmii_load) begin
            hold_q     <= rx_nib_valid_in ? rx_nib_in : 4'h0;
            hold_dv_q  <= rx_nib_valid_in;
            hold_er_q  <= rx_err_in;
            hold_crs_q <= rx_crs_in;
         end
      end
   end

   always @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         rx_nib_take_out <= 1'b0;
         rx_data_out     <= 4'h0;
         rx_dv_out       <= 1'b0;
         rx_er_out       <= 1'b0;
      end else begin
         rx_nib_take_out <= 1'b0;
         if (is_rmii) begin
            if (rise) begin
               rx_nib_take_out <= rmii_load;
               // upper lines idle low, low dibit sent first
               if (rmii_load) begin
                  rx_data_out <= rx_nib_valid_in
                                 ? {2'h0, rx_nib_in[1:0]} : 4'h0;
                  rx_dv_out   <= rmii_dv_only_in ? rx_nib_valid_in
                                 : (rx_nib_valid_in | rx_crs_in);
                  rx_er_out   <= rx_err_in;
               end else begin
                  // sel_q still shows the half this rise belongs to
                  rx_data_out <= {2'h0, sel_q ? hold_q[3:2]
                                              : hold_q[1:0]};
                  rx_dv_out   <= rmii_dv;
                  rx_er_out   <= hold_er_q;
               end
            end
         end else if (rise) begin
            rx_nib_take_out <= 1'b1;
            rx_data_out     <= rx_nib_valid_in ? rx_nib_in : 4'h0;
            rx_dv_out       <= rx_nib_valid_in;
            // rgmii has no separate error pin
            rx_er_out       <= is_rgmii ? 1'b0 : rx_err_in;
            if (is_rgmii) begin
               rx_dv_out <= rx_nib_valid_in;
            end
         end else if (fall && is_rgmii) begin
            // error shares the control line in the low clock phase
            rx_dv_out <= rx_err_in;
         end
      end
   end

endmodule

// >>> testbench/prx_rx_mac_if_asserts.sv
// port checker for the receive mac interface
// assumes mode is static while out of reset
`timescale 1ns/1ps
module prx_chk(input wire ref_clk_in,sys_rst_in,rmii_dv_only_in,
   rx_nib_valid_in,rx_err_in,rx_crs_in,rx_nib_take_out,rx_clk_out,
   rx_dv_out,rx_er_out,input wire [1:0] mode_in,
   input wire [3:0] rx_nib_in,rx_data_out);
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (sys_rst_in);
   sequence s_hi; ##20 $fell(rx_clk_out); endsequence
   property p_edge; $changed(rx_data_out) |-> $rose(rx_clk_out); endproperty
   a_edge: assert property (p_edge) else $error("data off rise");
   property p_zero; !rx_dv_out && !mode_in[1] |-> !rx_data_out; endproperty
   a_zero: assert property (p_zero) else $error("data not idle");
   property p_mii; rx_nib_take_out && !mode_in && rx_dv_out
      |-> rx_data_out==$past(rx_nib_in); endproperty
   a_mii: assert property (p_mii) else $error("bad nibble");
   property p_rmii; rx_nib_take_out && mode_in==2'h1 && !rmii_dv_only_in
      |-> rx_dv_out==($past(rx_crs_in)|$past(rx_nib_valid_in)); endproperty
   a_rmii: assert property (p_rmii) else $error("bad crs_dv");
   property p_rep; rx_nib_take_out && mode_in==2'h1 && rmii_dv_only_in
      |-> rx_dv_out==$past(rx_nib_valid_in); endproperty
   a_rep: assert property (p_rep) else $error("bad plain dv");
   property p_ctl; mode_in==2'h2 && $fell(rx_clk_out)
      |-> rx_dv_out==$past(rx_err_in) && !rx_er_out; endproperty
   a_ctl: assert property (p_ctl) else $error("bad ctl phase");
   property p_clk; $rose(rx_clk_out) && mode_in!=2'h1 |-> s_hi; endproperty
   a_clk: assert property (p_clk) else $error("bad clock");
   property p_err; rx_nib_take_out && !mode_in[1]
      |-> rx_er_out==$past(rx_err_in); endproperty
   a_err: assert property (p_err) else $error("bad error");
endmodule
bind prx_rx_mac_if prx_chk u_chk(.*);

// >>> testbench/prx_mac_model.sv
// far-side mac: keeps data seen while valid
// assumes the block's receive clock
`timescale 1ns/1ps
module prx_mac_model(input wire rx_clk_in,dv_in,input wire [3:0] d_in,
   output reg [3:0] seen_out);
   initial seen_out = 4'h0;
   // mid-period sample avoids racing the launch edge
   always @(negedge rx_clk_in) if (dv_in) seen_out <= d_in;
endmodule

// >>> testbench/prx_rx_mac_if_test.sv
// bench for the receive mac interface, one task a scenario
// assumes the bound checker and the mac model
`timescale 1ns/1ps
module prx_rx_mac_if_test;
   reg c=0,r=1,o=0,nv=0,er=0,cs=0;
   reg [1:0] m=2'h0;
   reg [3:0] nb=4'h0;
   wire tk,rc,dv,re;
   wire [3:0] d,sn;
   integer bad_count=0,samples_checked=0,i;
   prx_rx_mac_if uut(.ref_clk_in(c),.sys_rst_in(r),.mode_in(m),
      .rmii_dv_only_in(o),.rx_nib_in(nb),.rx_nib_valid_in(nv),
      .rx_err_in(er),.rx_crs_in(cs),.rx_nib_take_out(tk),
      .rx_clk_out(rc),.rx_data_out(d),.rx_dv_out(dv),.rx_er_out(re));
   prx_mac_model mac(.rx_clk_in(rc),.dv_in(dv),.d_in(d),.seen_out(sn));
   initial forever #5 c = ~c;
   task chk(input [3:0] s,e); begin
      samples_checked++;
      if (s!==e) begin
         bad_count++;
         $display("wrong value at %0t: %h vs %h",$time,s,e);
      end
   end endtask
   task conclude; begin
      $display("checked %0d wrong %0d",samples_checked,bad_count);
      if (bad_count==0 && samples_checked>0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   end endtask
   task rst(input [1:0] md,input dvo); begin
      @(negedge c); r=1; m=md; o=dvo;
      repeat(5) @(negedge c); r=0;
   end endtask
   task tk_w; begin
      @(negedge c);
      for (i=0;i<99&&tk!==1'b1;i++) @(negedge c);
   end endtask
   task t_mii; begin
      nb=4'hA; nv=1; rst(2'h0,0); tk_w;
      chk(d,4'hA); chk(re,4'h0);
      nv=0; er=1; repeat(20) @(negedge c); chk(sn,4'hA);
      tk_w; chk(d,4'h0); chk(dv,4'h0); chk(sn,4'hA);
      chk(re,4'h1); $display("mii done");
   end endtask
   task t_rmii; begin
      er=0; nb=4'h6; nv=1; rst(2'h1,0); tk_w; chk(d,4'h2);
      repeat(20) @(negedge c); chk(d,4'h1);
      repeat(18) @(negedge c); chk(d,4'h1);
      nv=0; cs=1; tk_w; chk(dv,4'h1);
      rst(2'h1,1); tk_w; chk(dv,4'h0); $display("rmii done");
   end endtask
   task t_rgmii; begin
      cs=0; er=1; rst(2'h2,0); tk_w; chk(dv,4'h0);
      repeat(20) @(negedge c); chk(dv,4'h1); chk(re,4'h0);
      $display("rgmii done");
   end endtask
   initial begin t_mii; t_rmii; t_rgmii; conclude; end
   initial begin #20000; bad_count++; conclude; end
endmodule
